/* design/act_map.svh */
// Constants of the array counter timebase: field codes, dividers, reset values.
// Assumes inclusion by act_pkg, act_timebase and the testbench only.
`ifndef ACT_MAP_SVH
`define ACT_MAP_SVH
`define ACT_SEL_DIV12 3'h0
`define ACT_SEL_DIV4 3'h1
`define ACT_SEL_T0OVF 3'h2
`define ACT_SEL_PIN_EDGE 3'h3
`define ACT_SEL_SYSCLK 3'h4
`define ACT_SEL_XOSC8 3'h5
`define ACT_DIV12_LAST 4'hB
`define ACT_DIV4_LAST 4'h3
`define ACT_XOSC_LAST 3'h7
`define ACT_CNT_RST 16'h0000
`define ACT_CNT_MAX 16'hFFFF
`define ACT_BYTE_RST 8'h00
`endif

/* design/act_pkg.sv */
// Types shared by the array counter timebase modules.
// Assumes act_map.svh is on the include path.
`include "act_map.svh"
package act_pkg;
  // Mode control bits as written by software
  typedef struct packed {
    logic idle_suspend;
    logic overflow_irq_enable;
    logic [2:0] timebase_select;
  } act_mode_t;
  // Software read strobes
  typedef struct packed {
    logic rd_low;
    logic rd_high;
  } act_rd_t;
endpackage : act_pkg

/* design/act_sync.sv */
// Two-flop synchroniser with a falling-edge pulse on the synchronised level.
// Assumes an asynchronous input and one system clock.
`timescale 1ns/10ps
module act_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Async level in
  input wire logic din,
  // Synchronised level and falling edge
  output logic dout,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'h1;
      sync_q <= 1'h1;
      prev_q <= 1'h1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign dout = sync_q;
  assign fall = prev_q & ~sync_q;
endmodule : act_sync

/* design/act_timebase.sv */
// Shared 16-bit timebase of the programmable_counter_array.
// Assumes one 20 MHz system clock; ext inputs are asynchronous pins.
`timescale 1ns/10ps
`include "act_map.svh"
module act_timebase
  import act_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Mode control
  input wire act_pkg::act_mode_t mode,
  input wire logic flag_clear,
  input wire logic cpu_idle,
  // Count sources
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  input wire logic ext_osc,
  // Software read port
  input wire act_pkg::act_rd_t rd,
  output logic [7:0] counter_low_byte,
  output logic [7:0] counter_high_byte,
  // Status
  output logic overflow_flag,
  output logic irq_req
);
  import act_pkg::*;

  // ************************************************************
  // Timebase sources
  // ************************************************************
  logic [3:0] pre_q;
  logic [2:0] osc_div_q;
  logic pin_fall;
  logic osc_fall;
  logic tick;
  logic run;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic wrap;

  // Prescaler for the divided system clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_q <= 4'h0;
    end else if (mode.timebase_select == `ACT_SEL_DIV12 && pre_q >= `ACT_DIV12_LAST) begin
      pre_q <= 4'h0;
    end else if (mode.timebase_select == `ACT_SEL_DIV4 && pre_q >= `ACT_DIV4_LAST) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // Oscillator divider on its own input edges
  // oscillator sampled first
  act_sync u_osc_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(ext_osc),
    .dout(),
    .fall(osc_fall)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_div_q <= 3'h0;
    end else if (osc_fall) begin
      osc_div_q <= osc_div_q + 3'h1;
    end
  end

  act_sync u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(external_count_input),
    .dout(),
    .fall(pin_fall)
  );

  always_comb begin
    unique case (mode.timebase_select)
      `ACT_SEL_DIV12: tick = (pre_q >= `ACT_DIV12_LAST);
      `ACT_SEL_DIV4: tick = (pre_q >= `ACT_DIV4_LAST);
      `ACT_SEL_T0OVF: tick = timer0_overflow;
      `ACT_SEL_PIN_EDGE: tick = pin_fall;
      `ACT_SEL_SYSCLK: tick = 1'h1;
      `ACT_SEL_XOSC8: tick = osc_fall && (osc_div_q == `ACT_XOSC_LAST);
      default: tick = 1'h0;
    endcase
  end

  // ************************************************************
  // Counter
  // ************************************************************
  // idle only stops when suspend set
  assign run = ~(cpu_idle & mode.idle_suspend);
  assign cnt_d = cnt_q + 16'h0001;
  assign wrap = run & tick & (cnt_q == `ACT_CNT_MAX);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= `ACT_CNT_RST;
    end else if (run && tick) begin
      cnt_q <= cnt_d;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] snap_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap_q <= `ACT_BYTE_RST;
    end else if (rd.rd_low) begin
      snap_q <= cnt_q[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      counter_low_byte <= `ACT_BYTE_RST;
      counter_high_byte <= `ACT_BYTE_RST;
    end else begin
      if (rd.rd_low) begin
        counter_low_byte <= cnt_q[7:0];
      end
      if (rd.rd_high) begin
        counter_high_byte <= snap_q;
      end
    end
  end

  // ************************************************************
  // Overflow flag and interrupt
  // ************************************************************
  // wrap sets flag, set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overflow_flag <= 1'h0;
    end else if (wrap) begin
      overflow_flag <= 1'h1;
    end else if (flag_clear) begin
      overflow_flag <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_req <= 1'h0;
    end else begin
      irq_req <= (overflow_flag | wrap) & mode.overflow_irq_enable
                 & ~(flag_clear & ~wrap);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
    (run && tick) |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("counter did not step by one");
  a_count_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_idle && mode.idle_suspend) |=> (cnt_q == $past(cnt_q)))
    else $error("counter moved while suspended");
  a_idle_runs: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_idle && !mode.idle_suspend && mode.timebase_select == `ACT_SEL_SYSCLK)
    |=> (cnt_q != $past(cnt_q)))
    else $error("counter stopped in idle");
  a_reserved_idle: assert property (@(posedge clk) disable iff (sys_rst)
    (mode.timebase_select[2:1] == 2'h3) |=> (cnt_q == $past(cnt_q)))
    else $error("counter moved on reserved code");
  a_wrap_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (run && tick && cnt_q == 16'hFFFF) |=> (overflow_flag && cnt_q == 16'h0000))
    else $error("wrap did not set flag");
  a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    (overflow_flag && !flag_clear) |=> overflow_flag)
    else $error("flag dropped without clear");
  a_irq_follow: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (irq_req == (overflow_flag && $past(mode.overflow_irq_enable))))
    else $error("interrupt request mismatch");
  a_snap_coherent: assert property (@(posedge clk) disable iff (sys_rst)
    (rd.rd_low ##1 (rd.rd_high && !rd.rd_low)) |=>
    (counter_high_byte == $past(cnt_q[15:8], 2)))
    else $error("high byte not from snapshot");
  a_read_free: assert property (@(posedge clk) disable iff (sys_rst)
    (rd.rd_low && run && mode.timebase_select == `ACT_SEL_SYSCLK)
    |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("read disturbed counting");
  a_pin_edge: assert property (@(posedge clk) disable iff (sys_rst)
    (mode.timebase_select == `ACT_SEL_PIN_EDGE && run && !pin_fall)
    |=> (cnt_q == $past(cnt_q)))
    else $error("count without input edge");
  a_osc_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (mode.timebase_select == `ACT_SEL_XOSC8 && !osc_fall) |=> (cnt_q == $past(cnt_q)))
    else $error("count without oscillator edge");
  a_byte_split: assert property (@(posedge clk) disable iff (sys_rst)
    rd.rd_low |=> (counter_low_byte == $past(cnt_q[7:0])))
    else $error("low byte mismatch");

endmodule : act_timebase

/* verification/act_timebase_tb.sv */
// Self-checking bench for act_timebase: drives every port at the falling edge.
// Assumes act_pkg and act_map.svh compiled first; no bus, plain strobes.
`timescale 1ns/10ps
`include "act_map.svh"
module act_timebase_tb;
  import act_pkg::*;
  logic clk, sys_rst, flag_clear, cpu_idle, timer0_overflow, external_count_input, ext_osc;
  act_mode_t mode;
  act_rd_t rd;
  logic [7:0] counter_low_byte, counter_high_byte;
  logic overflow_flag, irq_req;
  logic [15:0] base, v;
  int fails = 0;
  int comparisons = 0;
  int i;

  act_timebase act_timebase_inst (.clk(clk), .sys_rst(sys_rst), .mode(mode),
    .flag_clear(flag_clear), .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input), .ext_osc(ext_osc), .rd(rd),
    .counter_low_byte(counter_low_byte), .counter_high_byte(counter_high_byte),
    .overflow_flag(overflow_flag), .irq_req(irq_req));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ************************************
  // Tasks
  // ************************************
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  task stop_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Low byte read, gap idle cycles, then high byte read
  task read16(input int gap, output logic [15:0] r);
    rd.rd_low = 1'h1;
    @(negedge clk);
    rd.rd_low = 1'h0;
    repeat (gap) @(negedge clk);
    rd.rd_high = 1'h1;
    @(negedge clk);
    rd.rd_high = 1'h0;
    r = {counter_high_byte, counter_low_byte};
  endtask : read16

  task delta(input string name, input logic [15:0] exp);
    read16(0, v);
    check(name, v - base, exp);
  endtask : delta

  // Select, read, wait k cycles, read again: low-byte edges k+2 apart
  task run(input logic [2:0] sel, input int k, input logic [15:0] exp);
    mode.timebase_select = sel;
    @(negedge clk);
    read16(0, base);
    repeat (k) @(negedge clk);
    delta("count", exp);
  endtask : run

  // n events on one source: 0 count pin, 1 oscillator, 2 timer 0 pulse
  // pin paced below clk/4
  task events(input int which, input int n);
    for (int j = 0; j < n; j++) begin
      if (which == 0) external_count_input = 1'h0;
      else if (which == 1) ext_osc = 1'h0;
      else timer0_overflow = 1'h1;
      repeat (which == 2 ? 1 : 4) @(negedge clk);
      external_count_input = 1'h1;
      ext_osc = 1'h1;
      timer0_overflow = 1'h0;
      repeat (4) @(negedge clk);
    end
  endtask : events

  // ************************************
  // Tests
  // ************************************
  initial begin
    sys_rst = 1'h1;
    mode = '0;
    mode.timebase_select = `ACT_SEL_SYSCLK;
    {flag_clear, cpu_idle, timer0_overflow, rd} = '0;
    external_count_input = 1'h1;
    ext_osc = 1'h1;
    repeat (5) @(negedge clk);
    sys_rst = 1'h0;
    check("rst", {counter_high_byte, counter_low_byte}, 16'h0000);
    check("rst_flags", {14'h0000, overflow_flag, irq_req}, 16'h0000);
    run(`ACT_SEL_SYSCLK, 30, 16'h0020);
    run(`ACT_SEL_DIV12, 118, 16'h000A);
    run(`ACT_SEL_DIV4, 38, 16'h000A);
    run(3'h6, 40, 16'h0000);
    run(3'h7, 40, 16'h0000);
    for (i = 0; i < 3; i++) begin
      mode.timebase_select = i == 0 ? `ACT_SEL_PIN_EDGE
                           : (i == 1 ? `ACT_SEL_XOSC8 : `ACT_SEL_T0OVF);
      @(negedge clk);
      read16(0, base);
      events(i, i == 1 ? 16 : 5);
      repeat (6) @(negedge clk);
      delta("events", i == 1 ? 16'h0002 : 16'h0005);
    end
    cpu_idle = 1'h1;
    mode.idle_suspend = 1'h1;
    run(`ACT_SEL_SYSCLK, 30, 16'h0000);
    mode.idle_suspend = 1'h0;
    run(`ACT_SEL_SYSCLK, 30, 16'h0020);
    cpu_idle = 1'h0;
    i = 0;
    while (overflow_flag !== 1'h1 && i < 70000) begin
      @(negedge clk);
      i++;
    end
    check("wrap_flag", {15'h0000, overflow_flag}, 16'h0001);
    read16(0, v);
    check("wrap", v, 16'h0000);
    check("irq_off", {15'h0000, irq_req}, 16'h0000);
    repeat (238) @(negedge clk);
    read16(32, v);
    check("snapshot", v, 16'h00F0);
    mode.overflow_irq_enable = 1'h1;
    repeat (10) @(negedge clk);
    check("irq_on", {14'h0000, overflow_flag, irq_req}, 16'h0003);
    flag_clear = 1'h1;
    @(negedge clk);
    flag_clear = 1'h0;
    check("clear", {14'h0000, overflow_flag, irq_req}, 16'h0000);
    stop_test();
  end

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule : act_timebase_tb
